// file: common/data_space_defines.svh
// Address map, field positions and widths of the data-space access unit
`ifndef DATA_SPACE_DEFINES_SVH
`define DATA_SPACE_DEFINES_SVH

`define DSA_ADDR_W        16
`define DSA_DATA_W        16
`define DSA_PSV_BIT       15
`define DSA_SFR_FIRST     16'h0000
`define DSA_SFR_LAST      16'h07FF
`define DSA_RAM_BASE      16'h0800
`define DSA_RAM_LAST      16'h0FFF
`define DSA_RAM_WORDS     1024
`define DSA_RAM_AW        10
`define DSA_NEAR_W        13
`define DSA_NEAR_LAST     16'h1FFF
`define DSA_BYTE_STEP     16'h0001
`define DSA_WORD_STEP     16'h0002
`define DSA_LANE_LO       2'h1
`define DSA_LANE_HI       2'h2
`define DSA_LANE_BOTH     2'h3

`endif

// file: common/data_space_pkg.sv
// Types shared by the data-space access unit, the core-side model and the testbench
package data_space_pkg;

  typedef enum logic [1:0] {
    MODE_DIRECT16,
    MODE_NEAR13,
    MODE_INDIRECT
  } addr_mode_t;

  typedef enum logic [1:0] {
    EXT_NONE,
    SIGN_EXTEND_OP,
    ZERO_EXTEND_OP
  } ext_op_t;

  typedef enum logic [1:0] {
    REGION_SFR,
    REGION_RAM,
    REGION_HOLE,
    REGION_PSV
  } region_t;

  typedef struct packed {
    logic        valid;
    addr_mode_t  mode;
    logic [15:0] direct_addr;
    logic [15:0] pointer;
    logic        post_inc;
    logic        byte_op;
    ext_op_t     ext_op;
    logic [15:0] wdata;
    logic [15:0] wreg_old;
  } access_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [15:0] wreg_new;
    logic [15:0] pointer_next;
  } read_rsp_t;

  typedef struct packed {
    logic        done;
    logic        suppressed;
    logic [15:0] pointer_next;
  } write_rsp_t;

  typedef struct packed {
    logic        pulse;
    logic        on_write;
    logic [15:0] address;
  } trap_t;

  typedef struct packed {
    read_rsp_t  rd;
    write_rsp_t wr;
    trap_t      trap;
  } state_t;

  typedef struct packed {
    logic        strobe_rd;
    logic        strobe_wr;
    logic [14:0] word_addr;
    logic [1:0]  lane_en;
    logic [15:0] wdata;
  } sfr_bus_t;

endpackage : data_space_pkg

// file: src/data_ram_bank.sv
// Word-organised data RAM: two byte lanes, one shared word decode
`timescale 1ns/1ps
`default_nettype none
`include "data_space_defines.svh"

module data_ram_bank (
  input  wire logic                      clk_i,
  input  wire logic [`DSA_RAM_AW-1:0]    rd_index_i,
  output logic      [`DSA_DATA_W-1:0]    rd_word_o,
  input  wire logic [`DSA_RAM_AW-1:0]    wr_index_i,
  input  wire logic [1:0]                wr_lane_en_i,
  input  wire logic [`DSA_DATA_W-1:0]    wr_word_i
);

  logic [`DSA_DATA_W-1:0] mem [0:`DSA_RAM_WORDS-1];

  // Read is combinational so the unit can register its answer in one cycle
  assign rd_word_o = mem[rd_index_i];

  // Separate write lines per lane
  always_ff @(posedge clk_i) begin
    if (wr_lane_en_i[0]) begin
      mem[wr_index_i][7:0] <= wr_word_i[7:0];
    end
    if (wr_lane_en_i[1]) begin
      mem[wr_index_i][15:8] <= wr_word_i[15:8];
    end
  end

endmodule : data_ram_bank
`default_nettype wire

// file: src/data_space_access_unit.sv
// Data-space access unit: address decode, byte lanes, pointer step, address-error trap
//
// Notes on behaviour
// - Every effective address is a 16-bit byte address, 64 Kbytes total.
// - Bit 15 clear maps to memory; bit 15 set is the reserved program window.
// - Up to 2 Kbytes of RAM; reads outside implemented area return zero.
// - Words are 16 bits; low byte at even address, high byte at odd.
// - Byte read fetches the whole word and puts the chosen byte low.
// - One word decode, two byte lanes with separate write strobes.
// - Post-increment pointer steps one for bytes, two for words.
// - Word access at an odd address raises the address-error trap.
// - Misaligned read completes, misaligned write is dropped; trap follows either, only the read's when both coincide.
// - Byte load into a working register keeps its high byte.
// - Sign-extend byte to 16 bits, or zero-extend clearing the high byte.
// - Register region is 0x0000 to 0x07FF; unanswered addresses read zero.
// - Near region up to 0x1FFF reachable through a 13-bit direct field.
// - Whole space reachable through 16-bit direct field or pointer.
// - Read and write addresses come from independent generators.
`timescale 1ns/1ps
`default_nettype none
`include "data_space_defines.svh"

module data_space_access_unit (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire data_space_pkg::access_req_t rd_req_i,
  input  wire data_space_pkg::access_req_t wr_req_i,
  output data_space_pkg::read_rsp_t        rd_rsp_o,
  output data_space_pkg::write_rsp_t       wr_rsp_o,
  output data_space_pkg::sfr_bus_t         sfr_rd_o,
  output data_space_pkg::sfr_bus_t         sfr_wr_o,
  input  wire logic                        sfr_rd_hit_i,
  input  wire logic [15:0]                 sfr_rdata_i,
  output data_space_pkg::trap_t            trap_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [15:0] effective_address(input data_space_pkg::access_req_t req);
    logic [15:0] ea;
    case (req.mode)
      data_space_pkg::MODE_NEAR13:   ea = {3'h0, req.direct_addr[`DSA_NEAR_W-1:0]};
      data_space_pkg::MODE_INDIRECT: ea = req.pointer;
      default:                       ea = req.direct_addr;
    endcase
    return ea;
  endfunction : effective_address

  function automatic data_space_pkg::region_t region_of(input logic [15:0] ea);
    data_space_pkg::region_t reg_sel;
    if (ea[`DSA_PSV_BIT]) begin
      reg_sel = data_space_pkg::REGION_PSV;
    end else if (ea <= `DSA_SFR_LAST) begin
      reg_sel = data_space_pkg::REGION_SFR;
    end else if (ea >= `DSA_RAM_BASE && ea <= `DSA_RAM_LAST) begin
      reg_sel = data_space_pkg::REGION_RAM;
    end else begin
      reg_sel = data_space_pkg::REGION_HOLE;
    end
    return reg_sel;
  endfunction : region_of

  function automatic logic [`DSA_RAM_AW-1:0] ram_index(input logic [15:0] ea);
    logic [15:0] offset;
    offset = 16'(ea - `DSA_RAM_BASE);
    return offset[`DSA_RAM_AW:1];
  endfunction : ram_index

  function automatic logic [15:0] pointer_step(input data_space_pkg::access_req_t req);
    logic [15:0] step;
    step = req.byte_op ? `DSA_BYTE_STEP : `DSA_WORD_STEP;
    return req.post_inc ? 16'(req.pointer + step) : req.pointer;
  endfunction : pointer_step

  function automatic logic misaligned(input data_space_pkg::access_req_t req, input logic [15:0] ea);
    return req.valid && !req.byte_op && ea[0];
  endfunction : misaligned

  ////////////////////////////////////////////////////////////////////////////
  // Address paths, one per generator

  logic [15:0]             rd_ea;
  logic [15:0]             wr_ea;
  data_space_pkg::region_t rd_region;
  data_space_pkg::region_t wr_region;
  logic                    rd_misaligned;
  logic                    wr_misaligned;
  logic [1:0]              wr_lanes;
  logic [15:0]             wr_word;
  logic [1:0]              ram_lane_en;
  logic [15:0]             ram_rd_word;

  // Independent decoders; a read and a write may both act in one cycle
  assign rd_ea         = effective_address(rd_req_i);
  assign wr_ea         = effective_address(wr_req_i);
  assign rd_region     = region_of(rd_ea);
  assign wr_region     = region_of(wr_ea);
  assign rd_misaligned = misaligned(rd_req_i, rd_ea);
  assign wr_misaligned = misaligned(wr_req_i, wr_ea);

  // Byte data is mirrored on both lanes; the strobe picks the side
  assign wr_lanes = wr_req_i.byte_op ? (wr_ea[0] ? `DSA_LANE_HI : `DSA_LANE_LO) : `DSA_LANE_BOTH;
  assign wr_word  = wr_req_i.byte_op ? {wr_req_i.wdata[7:0], wr_req_i.wdata[7:0]} : wr_req_i.wdata;

  // Misaligned write executes but never reaches memory
  assign ram_lane_en = (wr_req_i.valid && !wr_misaligned && wr_region == data_space_pkg::REGION_RAM)
                       ? wr_lanes : 2'h0;

  always_comb begin
    sfr_rd_o           = '0;
    sfr_rd_o.strobe_rd = rd_req_i.valid && rd_region == data_space_pkg::REGION_SFR;
    sfr_rd_o.word_addr = rd_ea[15:1];
    sfr_rd_o.lane_en   = `DSA_LANE_BOTH;
    sfr_wr_o           = '0;
    sfr_wr_o.strobe_wr = wr_req_i.valid && !wr_misaligned
                         && wr_region == data_space_pkg::REGION_SFR;
    sfr_wr_o.word_addr = wr_ea[15:1];
    sfr_wr_o.lane_en   = wr_lanes;
    sfr_wr_o.wdata     = wr_word;
  end

  data_ram_bank u_ram (
    .clk_i        (clk_i),
    .rd_index_i   (ram_index(rd_ea)),
    .rd_word_o    (ram_rd_word),
    .wr_index_i   (ram_index(wr_ea)),
    .wr_lane_en_i (ram_lane_en),
    .wr_word_i    (wr_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered state

  data_space_pkg::state_t state;
  data_space_pkg::state_t next_state;

  logic [15:0] fetched_word;
  logic [7:0]  picked_byte;
  logic [15:0] loaded_value;

  always_comb begin
    next_state = state;
    fetched_word = 16'h0000;
    picked_byte  = 8'h00;
    loaded_value = 16'h0000;

    // Holes, program window and unanswered registers all read as zero
    case (rd_region)
      data_space_pkg::REGION_SFR: fetched_word = sfr_rd_hit_i ? sfr_rdata_i : 16'h0000;
      data_space_pkg::REGION_RAM: fetched_word = ram_rd_word;
      default:                    fetched_word = 16'h0000;
    endcase

    picked_byte  = rd_ea[0] ? fetched_word[15:8] : fetched_word[7:0];
    // Misaligned word read still completes, from the containing word
    loaded_value = rd_req_i.byte_op ? {8'h00, picked_byte} : fetched_word;

    next_state.rd.valid        = rd_req_i.valid;
    next_state.rd.pointer_next = pointer_step(rd_req_i);
    case (rd_req_i.ext_op)
      data_space_pkg::SIGN_EXTEND_OP: begin
        next_state.rd.data     = {{8{loaded_value[7]}}, loaded_value[7:0]};
        next_state.rd.wreg_new = {{8{loaded_value[7]}}, loaded_value[7:0]};
      end
      data_space_pkg::ZERO_EXTEND_OP: begin
        next_state.rd.data     = {8'h00, loaded_value[7:0]};
        next_state.rd.wreg_new = {8'h00, loaded_value[7:0]};
      end
      default: begin
        next_state.rd.data     = loaded_value;
        next_state.rd.wreg_new = rd_req_i.byte_op ? {rd_req_i.wreg_old[15:8], picked_byte}
                                                   : loaded_value;
      end
    endcase

    next_state.wr.done         = wr_req_i.valid;
    next_state.wr.suppressed   = wr_misaligned;
    next_state.wr.pointer_next = pointer_step(wr_req_i);

    // One pulse per cycle; a misaligned read is reported instead of a misaligned write in the same cycle
    next_state.trap.pulse = rd_misaligned || wr_misaligned;
    if (rd_misaligned) begin
      next_state.trap.on_write = 1'b0;
      next_state.trap.address  = rd_ea;
    end else if (wr_misaligned) begin
      next_state.trap.on_write = 1'b1;
      next_state.trap.address  = wr_ea;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_rsp_o = state.rd;
  assign wr_rsp_o = state.wr;
  assign trap_o   = state.trap;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_bad_read;
    rd_req_i.valid && !rd_req_i.byte_op && rd_ea[0];
  endsequence

  sequence s_trap_for_read(logic [15:0] addr);
    trap_o.pulse && !trap_o.on_write && trap_o.address == addr;
  endsequence

  property p_read_trap;
    logic [15:0] addr;
    (s_bad_read, addr = rd_ea) |=> s_trap_for_read(addr) ##1 !trap_o.pulse || trap_o.address != addr
                                  || $past(rd_misaligned);
  endproperty

  a_read_misalign_trap: assert property (p_read_trap)
    else $error("misaligned word read gave no trap with its address");

  a_trap_single_pulse: assert property (trap_o.pulse && !$past(rd_misaligned || wr_misaligned) |-> 1'b0)
    else $error("trap pulse without a misaligned access one cycle earlier");

  a_write_dropped_misalign: assert property (wr_misaligned |-> ram_lane_en == 2'h0 && !sfr_wr_o.strobe_wr
                                             ##1 wr_rsp_o.suppressed && trap_o.pulse)
    else $error("misaligned write reached memory or was not trapped");

  a_upper_half_zero: assert property (rd_req_i.valid && rd_ea[`DSA_PSV_BIT]
                                      && rd_req_i.ext_op == data_space_pkg::EXT_NONE
                                      |=> rd_rsp_o.valid && rd_rsp_o.data == 16'h0000)
    else $error("read in reserved upper half returned nonzero data");

  a_pointer_step_size: assert property (rd_req_i.valid && rd_req_i.post_inc
                                        |=> rd_rsp_o.pointer_next == 16'($past(rd_req_i.pointer)
                                            + ($past(rd_req_i.byte_op) ? 16'h0001 : 16'h0002)))
    else $error("post-increment pointer stepped by the wrong size");

  a_byte_low_lane: assert property (rd_req_i.valid && rd_req_i.byte_op && rd_req_i.ext_op == data_space_pkg::EXT_NONE
                                    |=> rd_rsp_o.data[15:8] == 8'h00
                                        && rd_rsp_o.data[7:0] == rd_rsp_o.wreg_new[7:0])
    else $error("byte read not on low lane");

  a_wreg_high_kept: assert property (rd_req_i.valid && rd_req_i.byte_op && rd_req_i.ext_op == data_space_pkg::EXT_NONE
                                     |=> rd_rsp_o.wreg_new[15:8] == $past(rd_req_i.wreg_old[15:8]))
    else $error("byte load disturbed the working register high byte");

  a_sign_extend_fill: assert property (rd_req_i.valid && rd_req_i.ext_op == data_space_pkg::SIGN_EXTEND_OP
                                       |=> rd_rsp_o.data[15:8] == {8{rd_rsp_o.data[7]}})
    else $error("sign extension filled the high byte wrongly");

  a_sfr_over_ram: assert property (wr_req_i.valid && wr_ea <= `DSA_SFR_LAST && !wr_misaligned
                                   |-> sfr_wr_o.strobe_wr && ram_lane_en == 2'h0)
    else $error("register region write also reached RAM");

  a_near_field_range: assert property (rd_req_i.mode == data_space_pkg::MODE_NEAR13
                                       |-> rd_ea <= `DSA_NEAR_LAST)
    else $error("near direct address escaped the near region");

  a_byte_write_lane: assert property (wr_req_i.valid && wr_req_i.byte_op && wr_region == data_space_pkg::REGION_RAM
                                      |-> ram_lane_en == (wr_ea[0] ? 2'h2 : 2'h1))
    else $error("byte write strobed the wrong lane");

endmodule : data_space_access_unit
`default_nettype wire

// file: verif/core_agen_model.sv
// Core-side model: the read and write address generators facing the unit
`timescale 1ns/1ps
`default_nettype none

module core_agen_model (
  input  wire logic                       clk_i,
  output var  data_space_pkg::access_req_t rd_req_o,
  output var  data_space_pkg::access_req_t wr_req_o,
  input  wire data_space_pkg::read_rsp_t  rd_rsp_i,
  input  wire data_space_pkg::write_rsp_t wr_rsp_i
);
  initial begin
    rd_req_o = '0;
    wr_req_o = '0;
  end

  // Unused address field carries the inverse, so a wrong mode pick shows
  function automatic data_space_pkg::access_req_t make_req(input data_space_pkg::addr_mode_t m,
      input logic [15:0] ea, input logic b, input data_space_pkg::ext_op_t x,
      input logic [15:0] wd, input logic [15:0] wold);
    data_space_pkg::access_req_t r;
    r.valid       = 1'b1;
    r.mode        = m;
    r.direct_addr = (m == data_space_pkg::MODE_INDIRECT) ? ~ea : ea;
    r.pointer     = (m == data_space_pkg::MODE_INDIRECT) ? ea : ~ea;
    r.post_inc    = 1'b1;
    r.byte_op     = b;
    r.ext_op      = x;
    r.wdata       = wd;
    r.wreg_old    = wold;
    return r;
  endfunction : make_req

  // Separate generators: read and write may run in the same cycle
  task automatic read_op(input data_space_pkg::addr_mode_t m, input logic [15:0] ea, input logic b,
      input data_space_pkg::ext_op_t x, input logic [15:0] wold, output data_space_pkg::read_rsp_t rsp);
    data_space_pkg::access_req_t r;
    r = make_req(m, ea, b, x, 16'h9C9C, wold);
    @(negedge clk_i);
    rd_req_o = r;
    @(negedge clk_i);
    rsp      = rd_rsp_i;
    rd_req_o = data_space_pkg::access_req_t'({1'b0, ~r[$bits(r)-2:0]});
  endtask : read_op

  task automatic write_op(input logic [15:0] ea, input logic b, input logic [15:0] wd,
      output data_space_pkg::write_rsp_t rsp);
    data_space_pkg::access_req_t r;
    r = make_req(data_space_pkg::MODE_INDIRECT, ea, b, data_space_pkg::EXT_NONE, wd, 16'h6363);
    @(negedge clk_i);
    wr_req_o = r;
    @(negedge clk_i);
    rsp      = wr_rsp_i;
    wr_req_o = data_space_pkg::access_req_t'({1'b0, ~r[$bits(r)-2:0]});
  endtask : write_op
endmodule : core_agen_model

`default_nettype wire

// file: verif/data_space_access_unit_tb_top.sv
// Self-checking testbench of the data-space access unit
`timescale 1ns/1ps
`default_nettype none

module data_space_access_unit_tb_top;
  logic                        clk_i;
  logic                        reset_n_i;
  data_space_pkg::access_req_t rd_req;
  data_space_pkg::access_req_t wr_req;
  data_space_pkg::read_rsp_t   rd_rsp;
  data_space_pkg::write_rsp_t  wr_rsp;
  data_space_pkg::sfr_bus_t    sfr_rd;
  data_space_pkg::sfr_bus_t    sfr_wr;
  data_space_pkg::sfr_bus_t    sfr_seen;
  data_space_pkg::trap_t       trap;
  logic                        sfr_rd_hit;
  logic [15:0]                 sfr_rdata;
  data_space_pkg::read_rsp_t   rr;
  data_space_pkg::write_rsp_t  ww;
  int                          failures;
  int                          checked;
  logic [15:0]                 holes [4] = '{16'h1000, 16'h7FFE, 16'h8000, 16'hFFFE};

  data_space_access_unit i_data_space_access_unit (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rd_req_i(rd_req), .wr_req_i(wr_req), .rd_rsp_o(rd_rsp),
    .wr_rsp_o(wr_rsp), .sfr_rd_o(sfr_rd), .sfr_wr_o(sfr_wr), .sfr_rd_hit_i(sfr_rd_hit),
    .sfr_rdata_i(sfr_rdata), .trap_o(trap));

  core_agen_model i_core_agen_model (
    .clk_i(clk_i), .rd_req_o(rd_req), .wr_req_o(wr_req), .rd_rsp_i(rd_rsp), .wr_rsp_i(wr_rsp));

  // One register word at 0x0020; elsewhere the data lines carry junk
  assign sfr_rd_hit = sfr_rd.strobe_rd && (sfr_rd.word_addr == 15'h0010);
  assign sfr_rdata  = sfr_rd_hit ? 16'hA5C3 : 16'h5A3C;

  always @(posedge clk_i) begin
    if (sfr_wr.strobe_wr) begin
      sfr_seen <= sfr_wr;
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input data_space_pkg::addr_mode_t m, input logic [15:0] ea, input logic b,
      input data_space_pkg::ext_op_t x, input logic [15:0] wold);
    i_core_agen_model.read_op(m, ea, b, x, wold, rr);
    check({15'h0, rr.valid}, 16'h0001);
  endtask : rd

  task automatic wr(input logic [15:0] ea, input logic b, input logic [15:0] wd);
    i_core_agen_model.write_op(ea, b, wd, ww);
    check({15'h0, ww.done}, 16'h0001);
  endtask : wr

  task automatic t_lanes;
    wr(16'h0800, 1'b0, 16'h1234);
    check(ww.pointer_next, 16'h0802);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0800, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'h1234);
    check(rr.pointer_next, 16'h0802);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0801, 1'b1, data_space_pkg::EXT_NONE, 16'hC300);
    check({8'h0, rr.data[7:0]}, 16'h0012);
    check(rr.wreg_new, 16'hC312);
    check(rr.pointer_next, 16'h0802);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0800, 1'b1, data_space_pkg::EXT_NONE, 16'h0000);
    check({8'h0, rr.data[7:0]}, 16'h0034);
    wr(16'h0802, 1'b0, 16'h5566);
    wr(16'h0803, 1'b1, 16'h00AB);
    check(ww.pointer_next, 16'h0804);
    wr(16'h0802, 1'b1, 16'h0011);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0802, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'hAB11);
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_extend;
    rd(data_space_pkg::MODE_INDIRECT, 16'h0803, 1'b1, data_space_pkg::SIGN_EXTEND_OP, 16'h0);
    check(rr.wreg_new, 16'hFFAB);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0802, 1'b1, data_space_pkg::SIGN_EXTEND_OP, 16'hFF00);
    check(rr.wreg_new, 16'h0011);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0803, 1'b1, data_space_pkg::ZERO_EXTEND_OP, 16'h1234);
    check(rr.wreg_new, 16'h00AB);
    $display("test extend done");
  endtask : t_extend

  task automatic t_map;
    for (int i = 0; i < 4; i++) begin
      wr(holes[i], 1'b0, 16'hFFFF);
      rd(data_space_pkg::MODE_DIRECT16, holes[i], 1'b0, data_space_pkg::EXT_NONE, 16'h0);
      check(rr.data, 16'h0000);
    end
    wr(16'h0FFE, 1'b0, 16'hBEEF);
    rd(data_space_pkg::MODE_DIRECT16, 16'h0FFE, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'hBEEF);
    rd(data_space_pkg::MODE_NEAR13, 16'hE802, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'hAB11);
    $display("test map done");
  endtask : t_map

  task automatic t_sfr;
    rd(data_space_pkg::MODE_INDIRECT, 16'h0020, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'hA5C3);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0030, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'h0000);
    wr(16'h0021, 1'b1, 16'h007E);
    check({1'b0, sfr_seen.word_addr}, 16'h0010);
    check({14'h0, sfr_seen.lane_en}, 16'h0002);
    check(sfr_seen.wdata, 16'h7E7E);
    check({15'h0, sfr_seen.strobe_rd}, 16'h0000);
    $display("test sfr done");
  endtask : t_sfr

  task automatic t_trap;
    wr(16'h0804, 1'b0, 16'h4321);
    check({15'h0, trap.pulse}, 16'h0000);
    wr(16'h0805, 1'b0, 16'hDEAD);
    check({15'h0, ww.suppressed}, 16'h0001);
    check({14'h0, trap.pulse, trap.on_write}, 16'h0003);
    check(trap.address, 16'h0805);
    @(negedge clk_i);
    check({15'h0, trap.pulse}, 16'h0000);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0804, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'h4321);
    rd(data_space_pkg::MODE_INDIRECT, 16'h0803, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
    check(rr.data, 16'hAB11);
    check({14'h0, trap.pulse, trap.on_write}, 16'h0002);
    check(trap.address, 16'h0803);
    fork
      rd(data_space_pkg::MODE_INDIRECT, 16'h0801, 1'b0, data_space_pkg::EXT_NONE, 16'h0);
      wr(16'h0807, 1'b0, 16'h0BAD);
    join
    check({14'h0, trap.pulse, trap.on_write}, 16'h0002);
    check(trap.address, 16'h0801);
    $display("test trap done");
  endtask : t_trap

  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    failures  = 0;
    checked   = 0;
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    check({15'h0, rd_rsp.valid}, 16'h0000);
    t_lanes();
    t_extend();
    t_map();
    t_sfr();
    t_trap();
    stop_test();
  end

  // Whole run needs about 66 cycles; far beyond that means a hang
  initial begin
    #(3000 * 50);
    failures++;
    stop_test();
  end
endmodule : data_space_access_unit_tb_top

`default_nettype wire
